// File: core/hw_irq_pkg.sv
// Package of offsets, bit positions and reset values for hardware interrupt flags
package hw_irq_pkg;
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] OFS_HW_PENDING = 8'h06;
  localparam logic [7:0] OFS_HW_ENABLE = 8'h0f;
  localparam logic [7:0] OFS_HW_OUT_ENABLE = 8'h13;
  localparam int BIT_LOOPBACK_A = 12;
  localparam int BIT_LOOPBACK_B = 11;
  localparam int BIT_TIME_TAG = 7;
  localparam int BIT_UNUSED_ONE = 4;
  localparam int BIT_ADDR_PARITY = 3;
  localparam int BIT_TERM_SUMMARY = 2;
  localparam int TAG_W = 16;
  localparam int TERM_ADDR_W = 6;
  localparam logic [15:0] EVENT_MASK = 16'h1888;
  localparam logic [15:0] ENABLE_RESET = 16'h0010;
  localparam logic [15:0] PENDING_RESET = 16'h0010;
  typedef enum logic [1:0] {
    LOOP_IDLE,
    LOOP_CHECK
  } loop_state_t;
endpackage

// File: core/loopback_checker.sv
// Loopback checker for one bus: validity of every echoed word, data match on last
`timescale 1ns/1ps
module loopback_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic txWordDone,
  input wire logic [15:0] txWord,
  input wire logic txLastWord,
  input wire logic rxWordValid,
  input wire logic rxWordError,
  input wire logic [15:0] rxWord,
  output logic loopFail
);
  import hw_irq_pkg::*;

  // ==========================================
  // Capture of transmitted word
  loop_state_t state;
  logic [15:0] heldWord;
  logic heldLast;
  wire echoSeen = (state == LOOP_CHECK) && (rxWordValid || rxWordError);
  wire mismatch = heldLast && (rxWord != heldWord);
  wire next_fail = echoSeen && (rxWordError || mismatch); // R1 R2

  // Arm on each transmitted word, check the next decoded word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LOOP_IDLE;
      heldWord <= 16'h0000;
      heldLast <= 1'b0;
      loopFail <= 1'b0;
    end else begin
      loopFail <= next_fail;
      case (state)
        LOOP_IDLE: begin
          if (txWordDone) begin
            state <= LOOP_CHECK; // R1
            heldWord <= txWord;
            heldLast <= txLastWord; // R2
          end
        end
        LOOP_CHECK: begin
          if (txWordDone) begin
            heldWord <= txWord;
            heldLast <= txLastWord;
          end else if (echoSeen) begin
            state <= LOOP_IDLE;
          end
        end
        default: state <= LOOP_IDLE;
      endcase
    end
  end

  // ==========================================
  // Checks
  fail_on_error_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    echoSeen && rxWordError |=> loopFail) else $error("echo error not flagged"); // R1
  fail_on_mismatch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    echoSeen && heldLast && rxWord != heldWord |=> loopFail) // R2
    else $error("last word mismatch not flagged");
endmodule

// File: core/hw_interrupt_flag_logic.sv
// Hardware interrupt pending, enable and output enable registers with flag sources
//
// Operation
// R1 - After each transmitted word, check the echoed word for sync, encoding, count, parity.
// R2 - For a message's last transmitted word, also compare echoed data with sent data.
// R3 - Bus A loopback failure sets bit 12; resets to 0.
// R4 - Bus B loopback failure sets bit 11; resets to 0.
// R5 - Loopback flags stay set until the host reads the pending register.
// R6 - Time-tag match bit 7 sets when the counter increments onto the match value.
// R7 - Read-only bit 3 flags even parity of address and parity latched at reset release.
// R8 - Bits 10-8 and 6-5 everywhere, and pending bits 1-0, read zero.
// R9 - Bit 4 is read-only and resets to 1.
// R10 - Enable and output enable bits 2-0 ignore writes and read 000.
// R11 - Pending bit 2 is high while any terminal pending bit is set.
// R12 - An event sets its pending bit only when its enable bit is set.
// R13 - A pending bit drives the request pin only when output enabled.
// R14 - Output-enabled pending bits are ORed into one active-low request.
// R15 - The summary bit is combinational and falls as soon as terminal bits clear.
`timescale 1ns/1ps
module hw_interrupt_flag_logic #(
  parameter int TAG_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [hw_irq_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [15:0] regWriteData,
  output logic [15:0] regReadData,
  input wire logic txWordDoneA,
  input wire logic txWordDoneB,
  input wire logic [15:0] txWord,
  input wire logic txLastWord,
  input wire logic rxWordValidA,
  input wire logic rxWordErrorA,
  input wire logic [15:0] rxWordA,
  input wire logic rxWordValidB,
  input wire logic rxWordErrorB,
  input wire logic [15:0] rxWordB,
  input wire logic timeTagIncrement,
  input wire logic [TAG_WIDTH-1:0] timeTagMatchValue,
  input wire logic [hw_irq_pkg::TERM_ADDR_W-1:0] terminalAddrParity,
  input wire logic [15:0] terminalPending,
  output logic [TAG_WIDTH-1:0] timeTagCount,
  output logic irqRequest_n
);
  import hw_irq_pkg::*;

  // Refuse counter widths other than the one the match logic serves
  if (TAG_WIDTH != TAG_W) begin
    $error("time tag counter must be 16 bits");
  end

  // ==========================================
  // Loopback checkers
  logic failA;
  logic failB;
  loopback_checker checkA (
    .ref_clk(ref_clk), .rst_n(rst_n), .txWordDone(txWordDoneA), .txWord(txWord),
    .txLastWord(txLastWord), .rxWordValid(rxWordValidA), .rxWordError(rxWordErrorA),
    .rxWord(rxWordA), .loopFail(failA)
  );
  loopback_checker checkB (
    .ref_clk(ref_clk), .rst_n(rst_n), .txWordDone(txWordDoneB), .txWord(txWord),
    .txLastWord(txLastWord), .rxWordValid(rxWordValidB), .rxWordError(rxWordErrorB),
    .rxWord(rxWordB), .loopFail(failB)
  );

  // ==========================================
  // Time tag counter and match event
  wire [TAG_WIDTH-1:0] nextCount = timeTagCount + 1'b1;
  wire tagMatch = timeTagIncrement && (nextCount == timeTagMatchValue); // R6

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) timeTagCount <= '0;
    else if (timeTagIncrement) timeTagCount <= nextCount;
  end

  // ==========================================
  // Address parity latched after reset release
  logic strapTaken;
  logic parityFail;
  wire evenOnes = ~(^terminalAddrParity); // R7

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapTaken <= 1'b0;
      parityFail <= 1'b0;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      parityFail <= evenOnes; // R7
    end
  end

  // ==========================================
  // Register decode
  function automatic logic hit(input logic [REG_ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs[REG_ADDR_W-1:0]);
  endfunction

  wire selPending = hit(regAddr, OFS_HW_PENDING);
  wire selEnable = hit(regAddr, OFS_HW_ENABLE);
  wire selOutEnable = hit(regAddr, OFS_HW_OUT_ENABLE);
  wire pendingRead = regRead && selPending; // R5

  // ==========================================
  // Enable, output enable and sticky pending flags
  logic [15:0] enableReg;
  logic [15:0] outEnableReg;
  logic [15:0] stickyFlags;
  logic [15:0] events;
  logic [15:0] next_sticky;
  logic summary;

  always_comb begin
    events = 16'h0000;
    events[BIT_LOOPBACK_A] = failA; // R3
    events[BIT_LOOPBACK_B] = failB; // R4
    events[BIT_TIME_TAG] = tagMatch; // R6
    events[BIT_ADDR_PARITY] = parityFail;
  end

  // Gated set wins over clear-on-read
  always_comb begin
    next_sticky = pendingRead ? 16'h0000 : stickyFlags; // R5
    next_sticky = next_sticky | (events & enableReg & EVENT_MASK); // R12
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enableReg <= ENABLE_RESET;
      outEnableReg <= ENABLE_RESET;
      stickyFlags <= 16'h0000; // R3 R4
    end else begin
      stickyFlags <= next_sticky & ~(16'h0001 << BIT_ADDR_PARITY);
      if (regWrite && selEnable) enableReg <= (regWriteData & EVENT_MASK) | ENABLE_RESET; // R10
      if (regWrite && selOutEnable)
        outEnableReg <= (regWriteData & EVENT_MASK) | ENABLE_RESET; // R10
    end
  end

  // ==========================================
  // Pending view, summary and request pin
  assign summary = |terminalPending; // R11 R15
  logic [15:0] pendingView;
  always_comb begin
    pendingView = stickyFlags | PENDING_RESET; // R8 R9
    pendingView[BIT_ADDR_PARITY] = parityFail && enableReg[BIT_ADDR_PARITY]; // R7
    pendingView[BIT_TERM_SUMMARY] = summary; // R11
  end

  wire [15:0] firing = pendingView & outEnableReg & EVENT_MASK; // R13
  assign irqRequest_n = ~(|firing); // R14

  wire [15:0] readMux = selPending ? pendingView :
                        selEnable ? enableReg :
                        selOutEnable ? outEnableReg : 16'h0000; // R8 R10

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) regReadData <= 16'h0000;
    else if (regRead) regReadData <= readMux;
  end

  // ==========================================
  // Checks
  loop_a_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stickyFlags[BIT_LOOPBACK_A] && !pendingRead |=> stickyFlags[BIT_LOOPBACK_A]) // R5
    else $error("bus A flag lost before read");
  loop_a_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    failA && enableReg[BIT_LOOPBACK_A] |=> stickyFlags[BIT_LOOPBACK_A]) // R3
    else $error("bus A failure not latched");
  loop_b_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    failB && enableReg[BIT_LOOPBACK_B] |=> stickyFlags[BIT_LOOPBACK_B]) // R4
    else $error("bus B failure not latched");
  read_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pendingRead && !failA |=> !stickyFlags[BIT_LOOPBACK_A]) // R5
    else $error("pending read did not clear");
  tag_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tagMatch && enableReg[BIT_TIME_TAG] |=> stickyFlags[BIT_TIME_TAG]) // R6
    else $error("time tag match not flagged");
  disabled_event_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !enableReg[BIT_TIME_TAG] && !stickyFlags[BIT_TIME_TAG] && !pendingRead
    |=> !stickyFlags[BIT_TIME_TAG]) // R12
    else $error("disabled event set pending");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRead |=> (regReadData & 16'h0763) == 16'h0000) // R8
    else $error("reserved bits not zero");
  bit_four_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRead && (selPending || selEnable || selOutEnable) |=> regReadData[BIT_UNUSED_ONE]) // R9
    else $error("bit 4 not one");
  enable_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    enableReg[2:0] == 3'h0 && outEnableReg[2:0] == 3'h0) // R10
    else $error("enable low bits written");
  summary_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pendingView[BIT_TERM_SUMMARY] == (terminalPending != 16'h0000)) // R11 R15
    else $error("summary bit wrong");
  irq_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqRequest_n == ((pendingView & outEnableReg & EVENT_MASK) == 16'h0000)) // R13 R14
    else $error("request pin disagrees");
  parity_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(strapTaken) |-> parityFail == $past(evenOnes)) // R7
    else $error("parity fail wrong");

  bus_a_fail_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    failA ##1 stickyFlags[BIT_LOOPBACK_A] ##[1:20] pendingRead);
  tag_hit_c: cover property (@(posedge ref_clk) disable iff (!rst_n) tagMatch);
  irq_fire_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(irqRequest_n));
endmodule

// File: tb/host_model.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  output logic [hw_irq_pkg::REG_ADDR_W-1:0] regAddr,
  output logic regRead,
  output logic regWrite,
  output logic [15:0] regWriteData,
  input wire logic [15:0] regReadData
);
  import hw_irq_pkg::*;
  // Idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regRead = 1'h0;
    regWrite = 1'h0;
    regWriteData = 16'h0000;
  end
  // One-cycle write strobe, data scrambled once released
  task automatic writeReg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'h1;
    @(posedge ref_clk);
    regWrite <= 1'h0;
    regWriteData <= ~d;
  endtask
  // One-cycle read strobe, data taken after the answering edge
  task automatic readReg(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge ref_clk);
    regRead <= 1'h0;
    #1;
    d = regReadData;
  endtask
endmodule

// File: tb/hw_interrupt_flag_logic_tb_top.sv
// Self-checking bench for the hardware interrupt flag block
`timescale 1ns/1ps
module hw_interrupt_flag_logic_tb_top;
  import hw_irq_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] regAddr;
  logic regRead, regWrite;
  logic [15:0] regWriteData, regReadData, txWord, rxWordA, rxWordB, timeTagCount;
  logic txWordDoneA = 1'h0, txWordDoneB = 1'h0, txLastWord = 1'h0, timeTagIncrement = 1'h0;
  logic rxWordValidA = 1'h0, rxWordErrorA = 1'h0, rxWordValidB = 1'h0, rxWordErrorB = 1'h0;
  logic [15:0] timeTagMatchValue = 16'h0003, terminalPending = 16'h0000;
  logic [5:0] terminalAddrParity = 6'h03;
  logic irqRequest_n;
  int err_total = 0;
  int compares = 0;
  initial begin
    txWord = 16'h0000;
    rxWordA = 16'h0000;
    rxWordB = 16'h0000;
  end
  // Clock generator
  always #50 ref_clk = ~ref_clk;
  host_model host_u (.ref_clk(ref_clk), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWriteData(regWriteData), .regReadData(regReadData));
  hw_interrupt_flag_logic #(.TAG_WIDTH(16)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData),
    .regReadData(regReadData), .txWordDoneA(txWordDoneA), .txWordDoneB(txWordDoneB),
    .txWord(txWord), .txLastWord(txLastWord), .rxWordValidA(rxWordValidA),
    .rxWordErrorA(rxWordErrorA), .rxWordA(rxWordA), .rxWordValidB(rxWordValidB),
    .rxWordErrorB(rxWordErrorB), .rxWordB(rxWordB), .timeTagIncrement(timeTagIncrement),
    .timeTagMatchValue(timeTagMatchValue), .terminalAddrParity(terminalAddrParity),
    .terminalPending(terminalPending), .timeTagCount(timeTagCount),
    .irqRequest_n(irqRequest_n));
  // Closing report
  task automatic results();
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Value comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read one register and compare
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_u.readReg(a, d);
    chk(d, exp);
  endtask
  // Transmit one word on a bus, then echo it back valid or broken
  task automatic loopWord(input logic busB, input logic last, input logic err,
      input logic [15:0] rx);
    @(posedge ref_clk);
    txWordDoneA <= !busB;
    txWordDoneB <= busB;
    txWord <= 16'h5a5a;
    txLastWord <= last;
    @(posedge ref_clk);
    txWordDoneA <= 1'h0;
    txWordDoneB <= 1'h0;
    @(posedge ref_clk);
    rxWordValidA <= !busB && !err;
    rxWordErrorA <= !busB && err;
    rxWordValidB <= busB && !err;
    rxWordErrorB <= busB && err;
    rxWordA <= rx;
    rxWordB <= rx;
    @(posedge ref_clk);
    {rxWordValidA, rxWordErrorA, rxWordValidB, rxWordErrorB} <= 4'h0;
    rxWordA <= ~rx;
    rxWordB <= ~rx;
    repeat (3) @(posedge ref_clk);
  endtask
  // Reset values, unmapped read, idle request
  task automatic scReset();
    rdChk(OFS_HW_PENDING, 16'h0010);
    rdChk(OFS_HW_ENABLE, 16'h0010);
    rdChk(OFS_HW_OUT_ENABLE, 16'h0010);
    rdChk(8'h20, 16'h0000);
    chk({15'h0, irqRequest_n}, 16'h0001);
  endtask
  // Disabled event and write to pending leave no trace
  task automatic scGating();
    loopWord(1'h0, 1'h0, 1'h1, 16'h5a5a);
    host_u.writeReg(OFS_HW_PENDING, 16'hffff);
    rdChk(OFS_HW_PENDING, 16'h0010);
  endtask
  // Writable bits, read-only and zero bits
  task automatic scRegs();
    host_u.writeReg(OFS_HW_ENABLE, 16'hffff);
    rdChk(OFS_HW_ENABLE, 16'h1898);
    host_u.writeReg(OFS_HW_OUT_ENABLE, 16'hffff);
    rdChk(OFS_HW_OUT_ENABLE, 16'h1898);
    host_u.writeReg(OFS_HW_OUT_ENABLE, 16'h1880);
    rdChk(OFS_HW_PENDING, 16'h0018);
  endtask
  // Bus A invalid echo, sticky through a good echo, cleared by read
  task automatic scLoopA();
    loopWord(1'h0, 1'h0, 1'h1, 16'h5a5a);
    chk({15'h0, irqRequest_n}, 16'h0000);
    loopWord(1'h0, 1'h1, 1'h0, 16'h5a5a);
    rdChk(OFS_HW_PENDING, 16'h1018);
    rdChk(OFS_HW_PENDING, 16'h0018);
    chk({15'h0, irqRequest_n}, 16'h0001);
  endtask
  // Bus B data compared on last word only
  task automatic scLoopB();
    loopWord(1'h1, 1'h0, 1'h0, 16'h0000);
    rdChk(OFS_HW_PENDING, 16'h0018);
    loopWord(1'h1, 1'h1, 1'h0, 16'h5a5b);
    rdChk(OFS_HW_PENDING, 16'h0818);
    rdChk(OFS_HW_PENDING, 16'h0018);
  endtask
  // Summary follows the terminal pending word
  task automatic scSummary();
    @(posedge ref_clk);
    terminalPending <= 16'h0100;
    rdChk(OFS_HW_PENDING, 16'h001c);
    chk({15'h0, irqRequest_n}, 16'h0001);
    @(posedge ref_clk);
    terminalPending <= 16'h0000;
    rdChk(OFS_HW_PENDING, 16'h0018);
  endtask
  // Three increments land on the match value
  task automatic scTag();
    @(posedge ref_clk);
    timeTagIncrement <= 1'h1;
    repeat (3) @(posedge ref_clk);
    timeTagIncrement <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk(timeTagCount, 16'h0003);
    chk({15'h0, irqRequest_n}, 16'h0000);
    rdChk(OFS_HW_PENDING, 16'h0098);
  endtask
  // Second reset with odd strap parity leaves bit 3 clear
  task automatic scStrap();
    @(posedge ref_clk);
    terminalAddrParity <= 6'h07;
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    host_u.writeReg(OFS_HW_ENABLE, 16'h0008);
    rdChk(OFS_HW_ENABLE, 16'h0018);
    rdChk(OFS_HW_PENDING, 16'h0010);
    chk(timeTagCount, 16'h0000);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    scReset();
    scGating();
    scRegs();
    scLoopA();
    scLoopB();
    scSummary();
    scTag();
    scStrap();
    results();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    results();
  end
endmodule
